// >>> rtl/osw_pkg.sv
/*
 Package for the oscillator switch controller: register map, field positions,
 key values, source codes, state encoding and timing constants.
 Assumes a 32-bit AXI4-Lite register bus and a 40 MHz core clock.
*/
package osw_pkg;

    // Register byte addresses
    localparam logic [7:0] OSW_ADDR_CTRL   = 8'h00;  // osc_control_reg
    localparam logic [7:0] OSW_ADDR_KEY    = 8'h04;  // system_key_reg
    localparam logic [7:0] OSW_ADDR_STATUS = 8'h08;  // Lock and oscillator state

    // Fields of osc_control_reg
    localparam int OSW_BIT_REQ  = 0;   // switch_request
    localparam int OSW_BIT_SEN  = 1;   // secondary_osc_enable
    localparam int OSW_NEW_OSC_SELECT_LO  = 8;   // new_osc_select low bit
    localparam int OSW_CURRENT_OSC_SELECT_LO  = 12;  // current_osc_select low bit
    localparam int OSW_SEL_W    = 3;

    // Fields of the status register
    localparam int OSW_ST_UNLOCK = 0;
    localparam int OSW_ST_RUN_LO = 4;  // Running mask, one bit per source

    // Unlock keys
    localparam logic [31:0] OSW_KEY1 = 32'hAA996655;
    localparam logic [31:0] OSW_KEY2 = 32'h556699AA;

    // Source select codes
    localparam logic [2:0] OSW_SRC_FRC     = 3'h0;
    localparam logic [2:0] OSW_SRC_FRCPLL  = 3'h1;
    localparam logic [2:0] OSW_SRC_PRIMARY_OSCILLATOR    = 3'h2;
    localparam logic [2:0] OSW_SRC_POSCPLL = 3'h3;
    localparam logic [2:0] OSW_SRC_SECONDARY_OSCILLATOR    = 3'h4;
    localparam logic [2:0] OSW_SRC_LOW_POWER_RC_OSCILLATOR    = 3'h5;
    localparam int         OSW_NSRC        = 8;

    // AXI responses
    localparam logic [1:0] OSW_RESP_OKAY   = 2'h0;
    localparam logic [1:0] OSW_RESP_SLVERR = 2'h2;

    // Start-up timer: time in microseconds and derived cycles at 40 MHz
    localparam int OSW_CLK_MHZ       = 40;
    localparam int OSW_OST_US        = 100;
    localparam int OSW_OST_CYC       = OSW_OST_US * OSW_CLK_MHZ;
    localparam int OSW_CNT_W         = 16;

    // Switch sequencer states, one-hot
    typedef enum logic [3:0] {
        OSW_IDLE  = 4'h1,
        OSW_START = 4'h2,
        OSW_LOCKW = 4'h4,
        OSW_HAND  = 4'h8
    } osw_state_t;

    // Configuration word fields
    typedef struct packed {
        logic       clock_switch_enable_cfg;  // Active low
        logic [2:0] default_osc_cfg;
        logic [1:0] primary_osc_mode_cfg;     // 2'h0 = external clock
        logic       clock_out_pin_select_cfg; // 1 = clock out, 0 = I/O
    } osw_cfg_t;

    localparam logic [1:0] OSW_PMODE_EC = 2'h0;

endpackage : osw_pkg

// >>> rtl/osw_ctrl.sv
/*
 Oscillator switch controller: key lock, oscillator control register,
 switch sequencer, oscillator enables, pin function select and a
 glitch-free source handover flag. AXI4-Lite slave for the registers.
 Assumes configuration word and oscillator status inputs are asynchronous.
*/
// Notes on behaviour
// RULE_01: Switching and fail-safe monitor enabled only when the config bit is low.
// RULE_02: With switching off, new select ignored; current shows default config source.
// RULE_03: With switching off, switch request reads zero and ignores writes.
// RULE_04: Request with equal current and new selection clears request, no change.
// RULE_05: Start requested oscillator; wait start-up timer for crystal sources.
// RULE_06: Hold switch until PLL lock when the new source uses the PLL.
// RULE_07: On completion clear request and copy new into current selection.
// RULE_08: Stop old oscillator after switch unless another module uses it.
// RULE_09: Core never stalls during a switch.
// RULE_10: Unlock only on first key then second key written to key register.
// RULE_11: Any access between the two key writes leaves registers locked.
// RULE_12: Stay unlocked until a non-key write; hardware never relocks itself. A first-key write to the key register relocks here too.
// RULE_13: Unlock opens every protected register, RTC control included.
// RULE_14: Absent or dead oscillator keeps request set and selection unchanged.
// RULE_15: Sleep during a switch aborts it, keeps selection, clears request.
// RULE_16: Direct switch between two PLL sources is refused.
// RULE_17: Software avoids sub-100 kHz clocks while fail-safe monitor is on.
// RULE_18: Secondary enable bit runs it; stops only when clear and unused.
// RULE_19: Secondary stays on while it is system clock, and in sleep if enabled.
// RULE_20: Oscillator control register is write-protected by the lock.
// RULE_21: Unused oscillator pins become I/O; clock out pin selected by config.
// RULE_22: At start-up the configured oscillator is loaded into current selection.
// RULE_23: Locked writes to protected fields are ignored; lock set after reset.
// RULE_24: Source handover happens without glitches on the system clock.
`timescale 1ns/1ps
module osw_ctrl (
    input  wire logic                core_clk_in,
    input  wire logic                nrst_in,
    input  wire osw_pkg::osw_cfg_t   cfg_in,
    input  wire logic [7:0]          osc_ready_in,      // Per-source running
    input  wire logic                pll_lock_in,
    input  wire logic [7:0]          osc_in_use_in,     // Other module users
    input  wire logic                sleep_in,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic [7:0]               osc_enable_out,
    output logic [2:0]               sys_clk_select_out,
    output logic                     handover_out,
    output logic                     unlocked_out,
    output logic                     failsafe_enable_out,
    output logic                     clk_out_pin_en_out,
    output logic                     crystal_pin_gpio_out,
    output logic                     secondary_pin_gpio_out,
    output logic                     switch_busy_out
);
    import osw_pkg::*;

    // Synchronisers for asynchronous inputs
    osw_cfg_t   cfg_s1_reg, cfg_s2_reg;
    logic [7:0] rdy_s1_reg, rdy_s2_reg;
    logic       lck_s1_reg, lck_s2_reg;
    logic       slp_s1_reg, slp_s2_reg;
    always_ff @(posedge core_clk_in) begin
        cfg_s1_reg <= cfg_in;
        cfg_s2_reg <= cfg_s1_reg;
        rdy_s1_reg <= osc_ready_in;
        rdy_s2_reg <= rdy_s1_reg;
        lck_s1_reg <= pll_lock_in;
        lck_s2_reg <= lck_s1_reg;
        slp_s1_reg <= sleep_in;
        slp_s2_reg <= slp_s1_reg;
    end

    // Switching allowed when the config bit is programmed low
    wire sw_en_w = ~cfg_s2_reg.clock_switch_enable_cfg;  // RULE_01

    // AXI handshake state
    logic       aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg, rvalid_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    wire aw_take_w = s_axi_awvalid & ~aw_hold_reg & ~bvalid_reg;
    wire w_take_w  = s_axi_wvalid & ~w_hold_reg & ~bvalid_reg;
    wire wr_go_w   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire ar_take_w = s_axi_arvalid & ~rvalid_reg;
    wire wr_ctrl_w = wr_go_w & (aw_addr_reg == OSW_ADDR_CTRL);
    wire wr_key_w  = wr_go_w & (aw_addr_reg == OSW_ADDR_KEY);
    wire wr_ok_w   = wr_go_w & (wr_ctrl_w | wr_key_w | (aw_addr_reg == OSW_ADDR_STATUS));
    wire rd_ok_w   = (s_axi_araddr == OSW_ADDR_CTRL) | (s_axi_araddr == OSW_ADDR_KEY)
                   | (s_axi_araddr == OSW_ADDR_STATUS);

    // Key sequence: armed after first key, unlocked after second key
    logic key_armed_reg, unlocked_reg;
    wire full_word_w  = (w_strb_reg == 4'hF);
    wire key1_w = wr_key_w & full_word_w & (w_data_reg == OSW_KEY1);
    wire key2_w = wr_key_w & full_word_w & (w_data_reg == OSW_KEY2) & key_armed_reg;
    wire any_access_w = wr_go_w | ar_take_w;
    wire key_armed_next = key1_w ? 1'b1 : (any_access_w ? 1'b0 : key_armed_reg);  // RULE_11
    wire unlocked_next  = key2_w ? 1'b1                                           // RULE_10
                        : (wr_key_w & ~key1_w & ~key2_w) ? 1'b0                   // RULE_12
                        : (wr_key_w & key1_w) ? 1'b0 : unlocked_reg;
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            key_armed_reg <= 1'b0;
            unlocked_reg  <= 1'b0;  // RULE_23
        end else begin
            key_armed_reg <= key_armed_next;
            unlocked_reg  <= unlocked_next;
        end
    end

    // Oscillator control register and sequencer
    osw_state_t          st_reg, st_next;
    logic [2:0]          new_osc_select_reg, current_osc_select_reg;
    logic                req_reg, sen_reg, init_reg;
    logic [OSW_CNT_W-1:0] ost_cnt_reg;

    wire ctrl_wr_w  = wr_ctrl_w & unlocked_reg & w_strb_reg[0] & w_strb_reg[1];  // RULE_20 RULE_23
    wire [2:0] new_osc_select_w_data = w_data_reg[OSW_NEW_OSC_SELECT_LO +: OSW_SEL_W];
    wire req_set_w  = ctrl_wr_w & w_data_reg[OSW_BIT_REQ] & sw_en_w;            // RULE_03
    wire is_pll_w   = (new_osc_select_reg == OSW_SRC_FRCPLL) | (new_osc_select_reg == OSW_SRC_POSCPLL);
    wire cur_pll_w  = (current_osc_select_reg == OSW_SRC_FRCPLL) | (current_osc_select_reg == OSW_SRC_POSCPLL);
    wire crystal_w  = (new_osc_select_reg == OSW_SRC_PRIMARY_OSCILLATOR) | (new_osc_select_reg == OSW_SRC_POSCPLL)
                    | (new_osc_select_reg == OSW_SRC_SECONDARY_OSCILLATOR);
    wire new_rdy_w  = rdy_s2_reg[new_osc_select_reg];
    wire ost_done_w = (ost_cnt_reg >= OSW_CNT_W'(OSW_OST_CYC)) | ~crystal_w;
    wire abort_w    = slp_s2_reg | ~sw_en_w;                                     // RULE_15

    // Next-state logic of the switch sequencer
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            OSW_IDLE: begin
                if (req_reg & ~abort_w & (new_osc_select_reg != current_osc_select_reg) & ~(is_pll_w & cur_pll_w)) begin
                    st_next = OSW_START;  // RULE_16
                end
            end
            OSW_START: begin
                if (abort_w) begin
                    st_next = OSW_IDLE;
                end else if (new_rdy_w & ost_done_w) begin
                    st_next = OSW_LOCKW;  // RULE_05 RULE_14
                end
            end
            OSW_LOCKW: begin
                if (abort_w) begin
                    st_next = OSW_IDLE;
                end else if (~is_pll_w | lck_s2_reg) begin
                    st_next = OSW_HAND;   // RULE_06
                end
            end
            OSW_HAND: begin
                st_next = OSW_IDLE;
            end
            default: begin
                st_next = OSW_IDLE;
            end
        endcase
    end

    // Sequencer registers; CPU never waits on it
    always_ff @(posedge core_clk_in) begin  // RULE_09
        if (!nrst_in) begin
            st_reg      <= OSW_IDLE;
            new_osc_select_reg    <= OSW_SRC_FRC;
            current_osc_select_reg    <= OSW_SRC_FRC;
            req_reg     <= 1'b0;
            sen_reg     <= 1'b0;
            init_reg    <= 1'b1;
            ost_cnt_reg <= '0;
        end else begin
            st_reg      <= st_next;
            // Holds at expiry so a long wait cannot wrap back below it
            ost_cnt_reg <= (st_reg != OSW_START) ? '0
                         : ost_done_w ? ost_cnt_reg : ost_cnt_reg + 1'b1;
            if (init_reg | ~sw_en_w) begin
                current_osc_select_reg <= cfg_s2_reg.default_osc_cfg;  // RULE_02 RULE_22
                new_osc_select_reg <= cfg_s2_reg.default_osc_cfg;
                init_reg <= 1'b0;
            end else if (st_reg == OSW_HAND) begin
                current_osc_select_reg <= new_osc_select_reg;                    // RULE_07 RULE_24
            end else if (ctrl_wr_w && st_reg == OSW_IDLE) begin
                new_osc_select_reg <= new_osc_select_w_data;
            end
            if (ctrl_wr_w) begin
                sen_reg <= w_data_reg[OSW_BIT_SEN];      // RULE_18
            end
            if (~sw_en_w | abort_w & req_reg) begin
                req_reg <= 1'b0;                         // RULE_03 RULE_15
            end else if (req_set_w) begin
                req_reg <= 1'b1;
            end else if (st_reg == OSW_HAND) begin
                req_reg <= 1'b0;                         // RULE_07
            end else if (st_reg == OSW_IDLE && req_reg &&
                         (new_osc_select_reg == current_osc_select_reg || (is_pll_w && cur_pll_w))) begin
                req_reg <= 1'b0;                         // RULE_04 RULE_16
            end
        end
    end

    // Oscillator enables per source
    logic [7:0] osc_en_next;
    for (genvar i = 0; i < OSW_NSRC; i++) begin : g_osc_en
        wire is_cur_w = (current_osc_select_reg == 3'(i));
        wire is_new_w = (new_osc_select_reg == 3'(i)) & (st_reg != OSW_IDLE);      // RULE_05
        wire is_sec_w = (3'(i) == OSW_SRC_SECONDARY_OSCILLATOR) & sen_reg;                // RULE_18 RULE_19
        assign osc_en_next[i] = is_cur_w | is_new_w | is_sec_w | osc_in_use_in[i];  // RULE_08
    end

    // Pin function select
    wire primary_oscillator_used_w = (current_osc_select_reg == OSW_SRC_PRIMARY_OSCILLATOR) | (current_osc_select_reg == OSW_SRC_POSCPLL);
    wire ec_mode_w   = primary_oscillator_used_w & (cfg_s2_reg.primary_osc_mode_cfg == OSW_PMODE_EC);
    wire clk_pin_w   = ec_mode_w & cfg_s2_reg.clock_out_pin_select_cfg;  // RULE_21
    wire xtal_gpio_w = ~primary_oscillator_used_w;                                      // RULE_21
    wire sec_gpio_w  = ~(sen_reg | current_osc_select_reg == OSW_SRC_SECONDARY_OSCILLATOR);            // RULE_21

    // Register read data
    wire [31:0] ctrl_rd_w = (32'(current_osc_select_reg) << OSW_CURRENT_OSC_SELECT_LO) | (32'(new_osc_select_reg) << OSW_NEW_OSC_SELECT_LO)
                          | (32'(sen_reg) << OSW_BIT_SEN) | (32'(req_reg) << OSW_BIT_REQ);
    wire [31:0] stat_rd_w = (32'(rdy_s2_reg) << OSW_ST_RUN_LO)
                          | (32'(unlocked_reg) << OSW_ST_UNLOCK);
    wire [31:0] rd_mux_w  = (s_axi_araddr == OSW_ADDR_CTRL)   ? ctrl_rd_w
                          : (s_axi_araddr == OSW_ADDR_STATUS) ? stat_rd_w : 32'h00000000;

    // AXI channel registers
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= OSW_RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= OSW_RESP_OKAY;
            rdata_reg   <= 32'h00000000;
        end else begin
            if (aw_take_w) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_go_w) begin
                aw_hold_reg <= 1'b0;
            end
            if (w_take_w) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_go_w) begin
                w_hold_reg <= 1'b0;
            end
            if (wr_go_w) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok_w ? OSW_RESP_OKAY : OSW_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (ar_take_w) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux_w;
                rresp_reg  <= rd_ok_w ? OSW_RESP_OKAY : OSW_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Registered outputs
    logic [7:0] osc_en_reg;
    logic       hand_reg, fs_reg, clkpin_reg, xg_reg, sg_reg, busy_reg;
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            osc_en_reg <= 8'h01;
            hand_reg   <= 1'b0;
            fs_reg     <= 1'b0;
            clkpin_reg <= 1'b0;
            xg_reg     <= 1'b1;
            sg_reg     <= 1'b1;
            busy_reg   <= 1'b0;
        end else begin
            osc_en_reg <= osc_en_next;
            hand_reg   <= (st_reg == OSW_HAND);
            fs_reg     <= sw_en_w & ~cfg_s2_reg.clock_switch_enable_cfg;  // RULE_01
            clkpin_reg <= clk_pin_w;
            xg_reg     <= xtal_gpio_w;
            sg_reg     <= sec_gpio_w;
            busy_reg   <= (st_reg != OSW_IDLE);
        end
    end

    assign s_axi_awready = aw_take_w;
    assign s_axi_wready  = w_take_w;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ar_take_w;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign osc_enable_out         = osc_en_reg;
    assign sys_clk_select_out     = current_osc_select_reg;
    assign handover_out           = hand_reg;
    assign unlocked_out           = unlocked_reg;  // RULE_13
    assign failsafe_enable_out    = fs_reg;
    assign clk_out_pin_en_out     = clkpin_reg;
    assign crystal_pin_gpio_out   = xg_reg;
    assign secondary_pin_gpio_out = sg_reg;
    assign switch_busy_out        = busy_reg;

    // Checks
    chk_req_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_03
        !sw_en_w |=> !req_reg) else $error("request set while switching disabled");
    chk_key_pair: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_10
        $rose(unlocked_reg) |-> $past(key2_w)) else $error("unlock without key pair");
    chk_key_gap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_11
        (key_armed_reg && ar_take_w && !wr_go_w) |=> !key_armed_reg)
        else $error("gap kept key armed");
    chk_no_relock: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_12
        $fell(unlocked_reg) |-> $past(wr_key_w)) else $error("relock by hardware");
    chk_locked_wr: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_23
        (wr_ctrl_w & !unlocked_reg) |=> $stable(sen_reg)) else $error("locked write took");
    chk_redundant: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_04
        (st_reg == OSW_IDLE && req_reg && new_osc_select_reg == current_osc_select_reg && !req_set_w && sw_en_w)
        |=> !req_reg && st_reg == OSW_IDLE) else $error("redundant switch ran");
    chk_handover: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_07
        (st_reg == OSW_HAND && !req_set_w) |=> (current_osc_select_reg == $past(new_osc_select_reg)) && !req_reg)
        else $error("handover did not copy");
    chk_pll_wait: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_06
        (st_reg == OSW_LOCKW && is_pll_w && !lck_s2_reg) |=> st_reg != OSW_HAND)
        else $error("switched without lock");
    chk_sleep_abort: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_15
        (slp_s2_reg && st_reg == OSW_START) |=> st_reg == OSW_IDLE && $stable(current_osc_select_reg))
        else $error("sleep did not abort");
    chk_sec_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_19
        (current_osc_select_reg == OSW_SRC_SECONDARY_OSCILLATOR) |=> osc_en_reg[OSW_SRC_SECONDARY_OSCILLATOR]) else $error("secondary_oscillator stopped");

    cov_unlock: cover property (@(posedge core_clk_in) disable iff (!nrst_in) key2_w);
    cov_switch: cover property (@(posedge core_clk_in) disable iff (!nrst_in) st_reg == OSW_HAND);
    cov_sleep:  cover property (@(posedge core_clk_in) disable iff (!nrst_in)
        slp_s2_reg && st_reg == OSW_START);
    cov_refused: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
        st_reg == OSW_IDLE && req_reg && is_pll_w && cur_pll_w);

    // Config follow, start-up timer and pin release
    chk_off_sel: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_02
        (!sw_en_w && !init_reg) |=> current_osc_select_reg == $past(cfg_s2_reg.default_osc_cfg))
        else $error("current select not from config");
    chk_ost_wait: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_05
        (st_reg == OSW_START && crystal_w && ost_cnt_reg < OSW_CNT_W'(OSW_OST_CYC))
        |=> st_reg != OSW_LOCKW) else $error("left start before timer expiry");
    chk_xtal_io: assert property (@(posedge core_clk_in) disable iff (!nrst_in)  // RULE_21
        !primary_oscillator_used_w |=> xg_reg) else $error("crystal pins not released");

endmodule : osw_ctrl

// >>> dv/osw_ctrl_tb.sv
/*
 Self-checking bench for the oscillator switch controller: key lock, switch
 sequencing, abort on sleep and bus errors over AXI4-Lite.
 Assumes osw_pkg and osw_ctrl from rtl/ are compiled first.
*/
`timescale 1ns/1ps
module osw_ctrl_tb;
    import osw_pkg::*;
    typedef struct {logic [31:0] e, m; logic [1:0] r;} osw_exp_t;
    logic        core_clk_in, nrst_in, pll_lock_in, sleep_in;
    osw_cfg_t    cfg_in;
    logic [7:0]  osc_ready_in, osc_in_use_in, s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  osc_enable_out;
    logic [2:0]  sys_clk_select_out;
    logic        handover_out, unlocked_out, failsafe_enable_out, clk_out_pin_en_out;
    logic        crystal_pin_gpio_out, secondary_pin_gpio_out, switch_busy_out;
    int          n_mismatch, samples_checked, n_hand;
    osw_exp_t    qr[$], ex;
    logic [1:0]  qb[$];

    osw_ctrl i_osw_ctrl (
        .core_clk_in, .nrst_in, .cfg_in, .osc_ready_in, .pll_lock_in, .osc_in_use_in,
        .sleep_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .osc_enable_out, .sys_clk_select_out,
        .handover_out, .unlocked_out, .failsafe_enable_out, .clk_out_pin_en_out,
        .crystal_pin_gpio_out, .secondary_pin_gpio_out, .switch_busy_out
    );

    // Clock, 25 ns period
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // Write: address and data offered together, response expected in queue
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = OSW_RESP_OKAY);
        qb.push_back(r);
        @(posedge core_clk_in);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    // Read: expected data under a mask noted before the request
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'h7703, input logic [1:0] r = OSW_RESP_OKAY);
        qr.push_back('{e, m, r});
        @(posedge core_clk_in);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Sync latency, then bounded wait for the sequencer to go idle
    task automatic settle();
        repeat (6) @(posedge core_clk_in);
        for (int i = 0; i < 6000 && switch_busy_out !== 1'b0; i++) @(posedge core_clk_in);
    endtask : settle

    // Response monitor, oldest note first
    always @(posedge core_clk_in) begin
        if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, qb.pop_front()}, {30'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready) begin
            ex = qr.pop_front();
            chk("rresp", {30'h0, ex.r}, {30'h0, s_axi_rresp});
            chk("rdata", ex.e & ex.m, s_axi_rdata & ex.m);
        end
    end

    // Handover pulses seen
    always @(posedge core_clk_in) if (handover_out === 1'b1) n_hand++;

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge core_clk_in);
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        cfg_in = '{1'b0, OSW_SRC_FRC, 2'h1, 1'b1};
        osc_ready_in = 8'hFB;
        osc_in_use_in = 8'h00;
        {pll_lock_in, sleep_in, nrst_in} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        rnd = 32'h65978941;
        repeat (6) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        rnd = lfsr(rnd);
        osc_in_use_in <= rnd[7:0];
        repeat (2) @(posedge core_clk_in);
        rd(OSW_ADDR_CTRL, 32'h0);
        rd(OSW_ADDR_STATUS, 32'h0FB0, 32'h0FF1);
        chk("failsafe_enable_out", 32'h1, {31'h0, failsafe_enable_out});
        wr(OSW_ADDR_CTRL, 32'h0503);
        rd(OSW_ADDR_CTRL, 32'h0);
        wr(OSW_ADDR_KEY, OSW_KEY1);
        rd(OSW_ADDR_STATUS, 32'h0, 32'h1);
        wr(OSW_ADDR_KEY, OSW_KEY2);
        rd(OSW_ADDR_STATUS, 32'h0, 32'h1);
        wr(OSW_ADDR_KEY, OSW_KEY1);
        wr(OSW_ADDR_KEY, OSW_KEY2);
        rd(OSW_ADDR_STATUS, 32'h1, 32'h1);
        chk("unlocked_out", 32'h1, {31'h0, unlocked_out});
        wr(OSW_ADDR_CTRL, 32'h0001);
        settle();
        rd(OSW_ADDR_CTRL, 32'h0);
        wr(OSW_ADDR_CTRL, 32'h0101);
        repeat (300) @(posedge core_clk_in);
        rd(OSW_ADDR_CTRL, 32'h0101);
        pll_lock_in <= 1'b1;
        settle();
        rd(OSW_ADDR_CTRL, 32'h1100);
        wr(OSW_ADDR_CTRL, 32'h0301);
        settle();
        rd(OSW_ADDR_CTRL, 32'h1000, 32'h7001);
        wr(OSW_ADDR_CTRL, 32'h0003);
        settle();
        rd(OSW_ADDR_CTRL, 32'h0002);
        chk("osc_enable_out", {24'h0, 8'h11 | osc_in_use_in}, {24'h0, osc_enable_out});
        wr(OSW_ADDR_CTRL, 32'h0203);
        repeat (300) @(posedge core_clk_in);
        rd(OSW_ADDR_CTRL, 32'h0203);
        chk("switch_busy_out", 32'h1, {31'h0, switch_busy_out});
        chk("secondary_pin_gpio_out", 32'h0, {31'h0, secondary_pin_gpio_out});
        sleep_in <= 1'b1;
        settle();
        rd(OSW_ADDR_CTRL, 32'h0202);
        sleep_in <= 1'b0;
        rd(8'h40, 32'h0, 32'h0, OSW_RESP_SLVERR);
        wr(8'h40, rnd, OSW_RESP_SLVERR);
        cfg_in <= '{1'b1, OSW_SRC_PRIMARY_OSCILLATOR, OSW_PMODE_EC, 1'b1};
        settle();
        chk("failsafe_enable_out", 32'h0, {31'h0, failsafe_enable_out});
        chk("sys_clk_select_out", {29'h0, OSW_SRC_PRIMARY_OSCILLATOR}, {29'h0, sys_clk_select_out});
        chk("clk_out_pin_en_out", 32'h1, {31'h0, clk_out_pin_en_out});
        chk("crystal_pin_gpio_out", 32'h0, {31'h0, crystal_pin_gpio_out});
        wr(OSW_ADDR_CTRL, 32'h0003);
        rd(OSW_ADDR_CTRL, 32'h2000, 32'h7001);
        cfg_in.clock_switch_enable_cfg <= 1'b0;
        do rnd = lfsr(rnd); while (rnd == OSW_KEY1 || rnd == OSW_KEY2);
        wr(OSW_ADDR_KEY, rnd);
        rd(OSW_ADDR_STATUS, 32'h0, 32'h1);
        chk("handover_out", 32'h2, n_hand);
        report_and_stop();
    end
endmodule : osw_ctrl_tb
